// File: iowd_pkg.sv
// Package for the I/O port watchdog timer: port addresses, fields, timing
package iowd_pkg;

  // ---------------------------------------------------------------
  // Port addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_UNIT_SELECT  = 16'h0865;
  localparam logic [15:0] ADDR_RELOAD_VALUE = 16'h0866;
  localparam logic [15:0] ADDR_CFG_FINISH   = 16'h0867;
  localparam logic [15:0] ADDR_START_CLEAR  = 16'h0868;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int          UNIT_SECONDS_BIT  = 7;
  localparam int          STATUS_BIT        = 0;
  localparam int          ARMED_BIT         = 1;
  localparam logic [7:0]  UNIT_RESET        = 8'h00;
  localparam logic [7:0]  RELOAD_RESET      = 8'h00;
  localparam logic [7:0]  COUNT_MIN         = 8'h01;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CLK_HZ            = 50_000_000;
  localparam int          SECOND_S          = 1;
  localparam int          MINUTE_S          = 60;
  localparam int          SECOND_CYCLES     = CLK_HZ * SECOND_S;

  // I/O write or read request from the host
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } iowd_req_t;

  typedef enum logic [1:0] {
    IOWD_IDLE,
    IOWD_LOADED,
    IOWD_READY,
    IOWD_RUN
  } iowd_state_t;

endpackage

// File: iowd_top.sv
// I/O port watchdog timer: byte-wide port registers, prescaler, countdown
`timescale 1ns/100ps
module iowd_top #(
  parameter int SECOND_CYCLES = iowd_pkg::SECOND_CYCLES,
  parameter int MINUTE_SECONDS = iowd_pkg::MINUTE_S
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Host I/O port access
  input  wire iowd_pkg::iowd_req_t i_req,
  output logic [7:0]             o_rdata,
  output logic                   o_rvalid,
  // Watchdog state
  output logic                   o_timeout,
  output logic                   o_running
);

  // ---------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------
  logic hit_unit;
  logic hit_reload;
  logic hit_finish;
  logic hit_start;
  logic wdata_zero;
  logic wr_unit;
  logic wr_reload;
  logic wr_finish;
  logic wr_start;
  assign hit_unit   = (i_req.addr == iowd_pkg::ADDR_UNIT_SELECT);
  assign hit_reload = (i_req.addr == iowd_pkg::ADDR_RELOAD_VALUE);
  assign hit_finish = (i_req.addr == iowd_pkg::ADDR_CFG_FINISH);
  assign hit_start  = (i_req.addr == iowd_pkg::ADDR_START_CLEAR);
  assign wdata_zero = (i_req.wdata == 8'h00);

  // The two sequencing ports only react to a zero byte
  assign wr_unit    = i_req.wr && hit_unit;
  assign wr_reload  = i_req.wr && hit_reload;
  assign wr_finish  = i_req.wr && hit_finish && wdata_zero;
  assign wr_start   = i_req.wr && hit_start && wdata_zero;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]            unit_q;
  logic [7:0]            reload_q;
  logic [7:0]            count_q;
  logic                  status_q;
  logic                  tick_sec;
  logic                  tick_unit;
  logic                  unit_secs;
  logic                  running;
  logic                  expire;
  logic [7:0]            flags;
  logic [7:0]            rdata_d;
  iowd_pkg::iowd_state_t state_q;

  // ---------------------------------------------------------------
  // Derived conditions
  // ---------------------------------------------------------------
  // Only the unit bit matters; the rest of the byte reads back as written
  assign unit_secs = unit_q[iowd_pkg::UNIT_SECONDS_BIT];
  assign running   = (state_q == iowd_pkg::IOWD_RUN);
  // Last unit of an enabled countdown
  assign expire    = running && tick_unit && (count_q == iowd_pkg::COUNT_MIN);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      unit_q <= iowd_pkg::UNIT_RESET;
    end else if (wr_unit) begin
      unit_q <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reload_q <= iowd_pkg::RELOAD_RESET;
    end else if (wr_reload) begin
      reload_q <= i_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Configuration sequence
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= iowd_pkg::IOWD_IDLE;
    end else if (wr_reload) begin
      if (i_req.wdata == 8'h00) begin
        state_q <= iowd_pkg::IOWD_IDLE;
      end else begin
        state_q <= iowd_pkg::IOWD_LOADED;
      end
    end else begin
      unique case (state_q)
        iowd_pkg::IOWD_IDLE: begin
          state_q <= iowd_pkg::IOWD_IDLE;
        end
        iowd_pkg::IOWD_LOADED: begin
          if (wr_finish) begin
            state_q <= iowd_pkg::IOWD_READY;
          end
        end
        iowd_pkg::IOWD_READY: begin
          if (wr_start) begin
            state_q <= iowd_pkg::IOWD_RUN;
          end
        end
        iowd_pkg::IOWD_RUN: begin
          if (expire) begin
            state_q <= iowd_pkg::IOWD_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic [31:0] pre_q;
  logic [7:0]  sec_q;
  assign tick_sec  = (pre_q == 32'(SECOND_CYCLES - 1));
  // A minute ends on the last second of the count of seconds
  assign tick_unit = tick_sec && (unit_secs || sec_q == 8'(MINUTE_SECONDS - 1));

  // Held at zero outside a run, so each run starts on a whole unit
  always_ff @(posedge i_clk) begin
    if (i_rst || state_q != iowd_pkg::IOWD_RUN) begin
      pre_q <= 32'h0000_0000;
    end else if (tick_sec) begin
      pre_q <= 32'h0000_0000;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || state_q != iowd_pkg::IOWD_RUN) begin
      sec_q <= 8'h00;
    end else if (tick_sec) begin
      sec_q <= (sec_q == 8'(MINUTE_SECONDS - 1)) ? 8'h00 : sec_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Countdown
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= iowd_pkg::RELOAD_RESET;
    end else if (wr_reload) begin
      count_q <= i_req.wdata;
    end else if (wr_start && state_q == iowd_pkg::IOWD_READY) begin
      count_q <= reload_q;
    end else if (running && tick_unit) begin
      count_q <= count_q - 8'h01;
    end
  end

  // Expiry wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_q <= 1'b0;
    end else if (expire) begin
      status_q <= 1'b1;
    end else if (wr_start && state_q == iowd_pkg::IOWD_IDLE) begin
      status_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  // Status port shows the sticky expiry flag and whether a run is active
  always_comb begin
    flags                       = 8'h00;
    flags[iowd_pkg::STATUS_BIT] = status_q;
    flags[iowd_pkg::ARMED_BIT]  = running;
  end

  always_comb begin
    unique case (i_req.addr)
      iowd_pkg::ADDR_UNIT_SELECT:  rdata_d = unit_q;
      iowd_pkg::ADDR_RELOAD_VALUE: rdata_d = count_q;
      iowd_pkg::ADDR_START_CLEAR:  rdata_d = flags;
      default:                     rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_timeout = status_q;
  assign o_running = running;

endmodule

// File: iowd_top_asserts.sv
// Port checker of the I/O port watchdog timer
`timescale 1ns/100ps
module iowd_top_asserts #(
  parameter int SECOND_CYCLES  = 10,
  parameter int MINUTE_SECONDS = 3
) (
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire iowd_pkg::iowd_req_t i_req,
  input wire logic [7:0]          o_rdata,
  input wire logic                o_rvalid,
  input wire logic                o_timeout,
  input wire logic                o_running
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic w6;
  logic w7;
  logic w8;
  assign w6 = i_req.wr && i_req.addr == 16'h0866;
  assign w7 = i_req.wr && i_req.addr == 16'h0867 && i_req.wdata == 8'h00;
  assign w8 = i_req.wr && i_req.addr == 16'h0868 && i_req.wdata == 8'h00;
  a_read_answer: assert property (i_req.rd |=> o_rvalid) else $error("no answer");
  a_answer_cause: assert property (o_rvalid |-> $past(i_req.rd)) else $error("stray answer");
  a_unmapped_zero: assert property (i_req.rd && i_req.addr == 16'h0869 |=> o_rdata == 8'h00)
    else $error("bad read");
  a_reload_halts: assert property (w6 |=> !o_running) else $error("no halt");
  a_expiry_stops: assert property ($rose(o_timeout) |-> ##[0:1] !o_running) else $error("still on");
  a_status_holds: assert property (o_timeout && !w8 |=> o_timeout) else $error("status lost");
  a_status_clear: assert property (w6 && i_req.wdata == 8'h00 ##2 w7 ##2 w8 |=> !o_timeout)
    else $error("not cleared");
  a_no_early_end: assert property ($rose(o_running) |-> (!$rose(o_timeout)) [*8]) else $error("early");
endmodule
bind iowd_top iowd_top_asserts #(.SECOND_CYCLES(SECOND_CYCLES), .MINUTE_SECONDS(MINUTE_SECONDS)) chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_timeout(o_timeout), .o_running(o_running));

// File: iowd_top_tb.sv
// Testbench of the I/O port watchdog timer
`timescale 1ns/100ps
module iowd_top_tb;
  logic                i_clk;
  logic                i_rst;
  iowd_pkg::iowd_req_t i_req;
  logic [7:0]          o_rdata;
  logic                o_rvalid, o_timeout, o_running;
  logic [7:0]          exp_q[$];
  int                  err_count, compares, n;

  iowd_top #(.SECOND_CYCLES(10), .MINUTE_SECONDS(3)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_timeout(o_timeout), .o_running(o_running));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task cmp_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask

  task cmp_data(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask

  task give_verdict;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One port access; a read notes the byte it should return
  task acc(input logic rd, input logic [15:0] a, input logic [7:0] d);
    if (rd) exp_q.push_back(d);
    @(posedge i_clk);
    #2 i_req = '{!rd, rd, a, d};
    @(posedge i_clk);
    #2 i_req = '0;
  endtask

  // Expiry must come no sooner than n units of per cycles and at most 2 cycles later
  task wt(input int per);
    int c;
    c = 0;
    while (o_timeout !== 1'b1 && c < 999) begin
      @(negedge i_clk);
      c++;
    end
    cmp_bit(c >= n * per && c <= n * per + 2, 1'b1);
    if (c >= 999) give_verdict;
  endtask

  always @(negedge i_clk) begin
    if (o_rvalid === 1'b1) cmp_data(o_rdata, exp_q.pop_front());
  end

  initial begin
    i_rst = 1'b1;
    i_req = '0;
    err_count = 0;
    compares = 0;
    n = $urandom(32'h492a84f8);
    repeat (5) @(posedge i_clk);
    #2 i_rst = 1'b0;
    acc(1, 16'h0869, 8'h00);
    for (int m = 0; m < 2; m++) begin
      n = $urandom % 3 + 1;
      acc(0, 16'h0865, m ? 8'h00 : 8'h80);
      acc(1, 16'h0865, m ? 8'h00 : 8'h80);
      acc(0, 16'h0866, 8'(n));
      acc(1, 16'h0866, 8'(n));
      acc(0, 16'h0868, 8'h00);
      acc(0, 16'h0867, 8'($urandom % 255 + 1));
      acc(0, 16'h0868, 8'h00);
      cmp_bit(o_running, 1'b0);
      acc(0, 16'h0867, 8'h00);
      acc(0, 16'h0868, 8'h00);
      cmp_bit(o_running, 1'b1);
      wt(m ? 30 : 10);
      cmp_bit(o_running, 1'b0);
      acc(1, 16'h0868, 8'h01);
      acc(0, 16'h0866, 8'h00);
      acc(0, 16'h0867, 8'h00);
      acc(0, 16'h0868, 8'h00);
      acc(1, 16'h0868, 8'h00);
      cmp_bit(o_timeout, 1'b0);
    end
    n = 3;
    acc(0, 16'h0865, 8'h80);
    acc(0, 16'h0866, 8'(n));
    acc(0, 16'h0867, 8'h00);
    acc(0, 16'h0868, 8'h00);
    repeat (15) @(posedge i_clk);
    acc(0, 16'h0866, 8'h00);
    cmp_bit(o_running, 1'b0);
    repeat (40) @(posedge i_clk);
    #2 cmp_bit(o_timeout, 1'b0);
    acc(0, 16'h0866, 8'(n));
    acc(0, 16'h0867, 8'h00);
    acc(0, 16'h0868, 8'h00);
    repeat (5) @(posedge i_clk);
    #2 i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    #2 i_rst = 1'b0;
    cmp_bit(o_running, 1'b0);
    acc(1, 16'h0865, 8'h00);
    acc(1, 16'h0866, 8'h00);
    repeat (3) @(posedge i_clk);
    cmp_bit(exp_q.size() == 0, 1'b1);
    give_verdict;
  end
endmodule
